/* src/adc_seq_params.svh */
// Contract
// - writing one to start begins a sequence; zero does nothing
// - hardware trigger enable clear: only software start works
// - hardware trigger enable set: selected source may start sequences
// - select codes 0,1,2 pick timer outputs, 6 external, rest reserved
// - conversion clock is master clock over 2*(prescaler+1)
// - start-up wait is (field+1)*8 conversion clock periods
// - sample-hold lasts field+1 conversion clock periods
// - channel disable write of one disables, zero unchanged
// - channel state bit reads one when enabled
// - channel done reads one only if enabled and converted
// - channel overrun stays set until status register read
// - result ready set on new result, cleared by last-result read
// - general overrun stays set until status register read
// - rx buffer end set at count zero, cleared by counter write
// - rx buffers full reads one when both counts are zero
// - last result loaded at each conversion end and held
// - interrupt enable write of one enables, zero no effect
// - low resolution clear gives 10-bit, set gives 8-bit results
// - sleep: power up, wait start-up, convert, power down; triggers still start sequences
// - result reads clear channel done; last read clears ready too
// - a rising edge of selected trigger starts a sequence only when idle
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
`define OFS_CONTROL      8'h00
`define OFS_MODE         8'h04
`define OFS_CH_ENABLE    8'h10
`define OFS_CH_DISABLE   8'h14
`define OFS_CH_STATE     8'h18
`define OFS_FLAGS        8'h1c
`define OFS_LAST_RESULT  8'h20
`define OFS_IRQ_ENABLE   8'h24
`define OFS_IRQ_MASK     8'h2c
`define OFS_RESULT_BASE  8'h30
`define OFS_RESULT_LAST  8'h4c
`define OFS_DMA_COUNT    8'h54
`define OFS_DMA_NEXT     8'h58
`define BIT_START        1
`define BIT_SWRST        0
`define MODE_WRITE_MASK  32'h0f1f3f3f
`define MODE_RESET       32'h00000000
`define SEL_TIMER0       3'h0
`define SEL_TIMER1       3'h1
`define SEL_TIMER2       3'h2
`define SEL_EXTERNAL     3'h6
`define STARTUP_UNIT     8
`define CONVERT_CLOCKS   10
`define FLAG_READY       16
`define FLAG_GOVR        17
`define FLAG_RXEND       18
`define FLAG_RXFULL      19
`endif

/* src/adc_seq_pkg.sv */
package adc_seq_pkg;
  typedef struct packed {
    logic [3:0] sampleHold;
    logic [2:0] resvA;
    logic [4:0] startup;
    logic [1:0] resvB;
    logic [5:0] prescaler;
    logic [1:0] resvC;
    logic       sleep;
    logic       lowResolution;
    logic [2:0] triggerSelect;
    logic       hwTriggerEnable;
  } mode_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_START  = 5'b00010,
    ST_SAMPLE = 5'b00100,
    ST_CONV   = 5'b01000,
    ST_NEXT   = 5'b10000
  } seq_state_e;
endpackage : adc_seq_pkg

/* src/adc_sequencer_control.sv */
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"
module adc_sequencer_control #(
  parameter int CHANNELS = 8,
  parameter int COUNT_W  = 16
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clkEn,
  input  wire adc_seq_pkg::bus_req_s busReq,
  output logic [31:0]               rdata,
  input  wire logic [2:0]           timerWaveOut,
  input  wire logic                 externalTriggerIn,
  output logic                      cellPowerOn,
  output logic                      cellSample,
  output logic                      cellConvert,
  output logic [2:0]                cellChannel,
  input  wire logic                 cellDone,
  input  wire logic [9:0]           cellResult,
  output logic                      dmaRequest,
  output logic                      dmaWide,
  input  wire logic                 dmaAck,
  output logic                      irq
);
  import adc_seq_pkg::*;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire logic wrCtl   = busReq.wr && busReq.addr == `OFS_CONTROL;
  wire logic wrMode  = busReq.wr && busReq.addr == `OFS_MODE;
  wire logic wrChEn  = busReq.wr && busReq.addr == `OFS_CH_ENABLE;
  wire logic wrChDis = busReq.wr && busReq.addr == `OFS_CH_DISABLE;
  wire logic wrIrqEn = busReq.wr && busReq.addr == `OFS_IRQ_ENABLE;
  wire logic wrCnt   = busReq.wr && busReq.addr == `OFS_DMA_COUNT;
  wire logic wrNext  = busReq.wr && busReq.addr == `OFS_DMA_NEXT;
  wire logic rdFlags = busReq.rd && busReq.addr == `OFS_FLAGS;
  wire logic rdLast  = busReq.rd && busReq.addr == `OFS_LAST_RESULT;
  wire logic rdChRes = busReq.rd && busReq.addr >= `OFS_RESULT_BASE
                       && busReq.addr <= `OFS_RESULT_LAST
                       && busReq.addr[1:0] == 2'b00;
  wire logic [2:0] rdChIdx = 3'((busReq.addr - `OFS_RESULT_BASE) >> 2);
  wire logic swReset = wrCtl && busReq.wdata[`BIT_SWRST];
  wire logic swStart = wrCtl && busReq.wdata[`BIT_START];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  mode_s                 mode_q;
  logic [CHANNELS-1:0]   chOn_q;
  logic [CHANNELS-1:0]   done_q;
  logic [CHANNELS-1:0]   ovr_q;
  logic                  ready_q;
  logic                  govr_q;
  logic                  rxEnd_q;
  logic [19:0]           irqEn_q;
  logic [9:0]            last_q;
  logic [2:0]            lastCh_q;
  logic [9:0]            chRes_q [CHANNELS];
  logic [COUNT_W-1:0]    rxCnt_q;
  logic [COUNT_W-1:0]    rxNext_q;
  logic [2:0]            trigSync1_q;
  logic [2:0]            trigSync2_q;
  logic                  extSync1_q;
  logic                  extSync2_q;
  logic                  trigPrev_q;
  seq_state_e            state_q;
  logic [6:0]            preCnt_q;
  logic [8:0]            tickCnt_q;
  logic [2:0]            ch_q;
  logic [CHANNELS-1:0]   pend_q;

  // ---------------------------------------------------------------
  // trigger select and edge detect
  // ---------------------------------------------------------------
  logic trigSel;
  always_comb begin
    case (mode_q.triggerSelect)
      `SEL_TIMER0:   trigSel = trigSync2_q[0];
      `SEL_TIMER1:   trigSel = trigSync2_q[1];
      `SEL_TIMER2:   trigSel = trigSync2_q[2];
      `SEL_EXTERNAL: trigSel = extSync2_q;
      default:       trigSel = 1'b0;
    endcase
  end
  wire logic hwStart = mode_q.hwTriggerEnable && trigSel
                       && !trigPrev_q;
  // triggers during a running sequence are dropped, not queued
  wire logic startReq = (swStart || hwStart) && state_q == ST_IDLE;

  // ---------------------------------------------------------------
  // conversion clock tick and timing
  // ---------------------------------------------------------------
  wire logic [6:0] preLimit = {mode_q.prescaler, 1'b1};
  wire logic tick = preCnt_q == preLimit;
  wire logic [8:0] startTicks =
    9'((mode_q.startup + 9'd1) * `STARTUP_UNIT);
  wire logic [8:0] shTicks = 9'(mode_q.sampleHold) + 9'd1;
  wire logic [CHANNELS-1:0] remaining = pend_q & chOn_q;

  function automatic logic [2:0] firstSet(input logic [7:0] v);
    firstSet = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        firstSet = 3'(i);
      end
    end
  endfunction : firstSet

  // results are stored only when the cell reports done in convert
  wire logic convEnd = state_q == ST_CONV && cellDone;
  wire logic [9:0] resVal = mode_q.lowResolution ?
    {2'b00, cellResult[9:2]} : cellResult;
  wire logic [7:0] doneClr =
    (rdChRes ? 8'(1 << rdChIdx) : 8'h00) |
    (rdLast  ? 8'(1 << lastCh_q) : 8'h00);
  wire logic [7:0] convBit = convEnd ? 8'(1 << ch_q) : 8'h00;
  wire logic rxFull = rxCnt_q == '0 && rxNext_q == '0;
  wire logic dmaTake = dmaAck && rxCnt_q != '0;

  wire logic [31:0] flagWord = {12'h000, rxFull, rxEnd_q, govr_q,
    ready_q, ovr_q, done_q & chOn_q};
  logic [31:0] rdMux;
  always_comb begin
    case (busReq.addr)
      `OFS_MODE:        rdMux = 32'(mode_q) & `MODE_WRITE_MASK;
      `OFS_CH_STATE:    rdMux = {24'h0, chOn_q};
      `OFS_FLAGS:       rdMux = flagWord;
      `OFS_LAST_RESULT: rdMux = {22'h0, last_q};
      `OFS_IRQ_MASK:    rdMux = {12'h0, irqEn_q};
      `OFS_DMA_COUNT:   rdMux = 32'(rxCnt_q);
      `OFS_DMA_NEXT:    rdMux = 32'(rxNext_q);
      default:          rdMux = rdChRes ? {22'h0, chRes_q[rdChIdx]} : 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // clocked state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trigSync1_q <= 3'h0;
      trigSync2_q <= 3'h0;
      extSync1_q  <= 1'b0;
      extSync2_q  <= 1'b0;
    end else if (clkEn) begin
      trigSync1_q <= timerWaveOut;
      trigSync2_q <= trigSync1_q;
      extSync1_q  <= externalTriggerIn;
      extSync2_q  <= extSync1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || (clkEn && swReset)) begin
      mode_q  <= mode_s'(28'(`MODE_RESET));
      chOn_q  <= '0;
      irqEn_q <= 20'h0;
      rxCnt_q <= '0;
      rxNext_q <= '0;
      trigPrev_q <= 1'b0;
      rdata   <= 32'h0;
    end else if (clkEn) begin
      trigPrev_q <= trigSel;
      rdata <= busReq.rd ? rdMux : 32'h0;
      if (wrMode) mode_q <= mode_s'(28'(busReq.wdata & `MODE_WRITE_MASK));
      // disable wins when both touch a bit in one write, never both
      chOn_q <= (chOn_q | (wrChEn ? busReq.wdata[7:0] : 8'h0))
                & ~(wrChDis ? busReq.wdata[7:0] : 8'h0);
      if (wrIrqEn) irqEn_q <= irqEn_q | busReq.wdata[19:0];
      if (wrCnt) rxCnt_q <= busReq.wdata[COUNT_W-1:0];
      else if (dmaTake && rxCnt_q == 1 && rxNext_q != '0) begin
        rxCnt_q  <= rxNext_q;
        rxNext_q <= '0;
      end else if (dmaTake) rxCnt_q <= rxCnt_q - 1'b1;
      if (wrNext) rxNext_q <= busReq.wdata[COUNT_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || (clkEn && swReset)) begin
      done_q   <= '0;
      ovr_q    <= '0;
      ready_q  <= 1'b0;
      govr_q   <= 1'b0;
      rxEnd_q  <= 1'b0;
      last_q   <= 10'h0;
      lastCh_q <= 3'h0;
      dmaRequest <= 1'b0;
      irq      <= 1'b0;
      for (int i = 0; i < CHANNELS; i++) chRes_q[i] <= 10'h0;
    end else if (clkEn) begin
      // set wins over a clearing read in the same cycle
      done_q  <= (done_q & ~doneClr) | convBit;
      ovr_q   <= (rdFlags ? '0 : ovr_q)
                 | (convBit & done_q);
      govr_q  <= (rdFlags ? 1'b0 : govr_q)
                 | (convEnd && ready_q);
      ready_q <= (ready_q && !rdLast) || convEnd;
      if (wrCnt || wrNext) rxEnd_q <= 1'b0;
      else if (dmaTake && rxCnt_q == 1) rxEnd_q <= 1'b1;
      dmaRequest <= (dmaRequest && !dmaAck) || (convEnd && !rxFull);
      if (convEnd) begin
        last_q   <= resVal;
        lastCh_q <= ch_q;
        chRes_q[ch_q] <= resVal;
      end
      irq <= |(flagWord[19:0] & irqEn_q);
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst || (clkEn && swReset)) begin
      state_q     <= ST_IDLE;
      preCnt_q    <= 7'h0;
      tickCnt_q   <= 9'h0;
      ch_q        <= 3'h0;
      pend_q      <= '0;
      cellPowerOn <= 1'b0;
      cellSample  <= 1'b0;
      cellConvert <= 1'b0;
      cellChannel <= 3'h0;
    end else if (clkEn) begin
      preCnt_q <= tick ? 7'h0 : preCnt_q + 7'h1;
      case (state_q)
        ST_IDLE: begin
          cellPowerOn <= !mode_q.sleep;
          if (startReq && chOn_q != '0) begin
            pend_q      <= chOn_q;
            tickCnt_q   <= 9'h0;
            // divider restarts so the start-up wait is whole ticks
            preCnt_q    <= 7'h0;
            cellPowerOn <= 1'b1;
            // a powered cell needs no start-up wait
            state_q     <= mode_q.sleep ? ST_START : ST_NEXT;
          end
        end
        ST_START: if (tick) begin
          tickCnt_q <= tickCnt_q + 9'h1;
          if (tickCnt_q + 9'h1 >= startTicks) state_q <= ST_NEXT;
        end
        ST_NEXT: begin
          if (remaining == '0) begin
            state_q     <= ST_IDLE;
            cellPowerOn <= !mode_q.sleep;
          end else begin
            ch_q        <= firstSet(remaining);
            cellChannel <= firstSet(remaining);
            tickCnt_q   <= 9'h0;
            // aligned divider keeps sample-hold an exact tick count
            preCnt_q    <= 7'h0;
            cellSample  <= 1'b1;
            state_q     <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: if (tick) begin
          tickCnt_q <= tickCnt_q + 9'h1;
          if (tickCnt_q + 9'h1 >= shTicks) begin
            cellSample  <= 1'b0;
            cellConvert <= 1'b1;
            state_q     <= ST_CONV;
          end
        end
        ST_CONV: if (cellDone) begin
          cellConvert <= 1'b0;
          pend_q[ch_q] <= 1'b0;
          state_q     <= ST_NEXT;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) dmaWide <= 1'b1;
    else if (clkEn) dmaWide <= !mode_q.lowResolution;
  end
endmodule : adc_sequencer_control
`default_nettype wire

/* verification/adc_cell_model.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_cell_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       cellConvert,
  input  wire logic [2:0] cellChannel,
  input  wire logic       dmaRequest,
  output logic            cellDone,
  output logic [9:0]      cellResult,
  output logic            dmaAck
);
  logic [3:0] waitQ;
  logic       slowQ;
  logic       gapQ;
  // off-pulse value is inverted so a stale capture shows
  assign cellResult = cellDone ? (10'h2a0 | 10'(cellChannel))
                               : ~(10'h2a0 | 10'(cellChannel));
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      waitQ    <= 4'h0;
      slowQ    <= 1'b0;
      cellDone <= 1'b0;
      dmaAck   <= 1'b0;
      gapQ     <= 1'b0;
    end else begin
      // alternate prompt and slow answers
      cellDone <= cellConvert && !cellDone && waitQ == (slowQ ? 4'h9 : 4'h2);
      waitQ    <= (cellConvert && !cellDone) ? waitQ + 4'h1 : 4'h0;
      if (cellDone) slowQ <= !slowQ;
      dmaAck   <= dmaRequest && !dmaAck && !gapQ;
      gapQ     <= dmaAck;
    end
  end
endmodule : adc_cell_model
`default_nettype wire

/* verification/adc_sequencer_control_checker.sv */
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"
module adc_seq_checker #(
  parameter int CHANNELS = 8,
  parameter int COUNT_W  = 16
) (
  input wire logic                  core_clk,
  input wire logic                  sys_rst,
  input wire logic                  clkEn,
  input wire adc_seq_pkg::bus_req_s busReq,
  input wire logic [31:0]           rdata,
  input wire logic                  cellPowerOn,
  input wire logic                  cellSample,
  input wire logic                  cellConvert,
  input wire logic [2:0]            cellChannel,
  input wire logic                  cellDone,
  input wire logic                  dmaRequest,
  input wire logic                  dmaWide,
  input wire logic                  dmaAck
);
  import adc_seq_pkg::*;
  mode_s       modeQ;
  logic [7:0]  chanQ;
  logic [15:0] sampleCnt;
  logic [15:0] shLen;
  wire         wrEn = busReq.wr && busReq.addr == `OFS_CH_ENABLE;
  wire         wrDis = busReq.wr && busReq.addr == `OFS_CH_DISABLE;
  wire         swRst = busReq.wr && busReq.addr == `OFS_CONTROL
                       && busReq.wdata[`BIT_SWRST];
  assign shLen = (16'(modeQ.sampleHold) + 16'h1)
               * (16'(modeQ.prescaler) + 16'h1) * 16'h2;
  always_ff @(posedge core_clk) begin
    if (sys_rst || (clkEn && swRst)) begin
      modeQ     <= '0;
      chanQ     <= 8'h00;
      sampleCnt <= 16'h0;
    end else if (clkEn) begin
      if (busReq.wr && busReq.addr == `OFS_MODE)
        modeQ <= mode_s'(28'(busReq.wdata & `MODE_WRITE_MASK));
      chanQ     <= (chanQ | (wrEn ? busReq.wdata[7:0] : 8'h00))
                 & ~(wrDis ? busReq.wdata[7:0] : 8'h00);
      sampleCnt <= cellSample ? sampleCnt + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst || !clkEn);
  sequence convHold;
    cellConvert && !cellDone;
  endsequence
  read_idle_zero_a: assert property (!busReq.rd |=> rdata == 32'h0)
    else $error("read data not zero outside read answer");
  unmapped_read_a: assert property (busReq.rd && busReq.addr == 8'h08
    |=> rdata == 32'h0) else $error("unmapped read not zero");
  mode_readback_a: assert property (busReq.rd && busReq.addr == `OFS_MODE
    |=> rdata == 32'(modeQ)) else $error("mode readback wrong");
  chan_state_a: assert property (busReq.rd
    && busReq.addr == `OFS_CH_STATE
    |=> rdata == {24'h0, chanQ}) else $error("channel state wrong");
  sample_len_a: assert property ($fell(cellSample)
    |-> sampleCnt == shLen)
    else $error("sample hold length wrong");
  phase_excl_a: assert property (!(cellSample && cellConvert))
    else $error("sample and convert overlap");
  convert_hold_a: assert property (convHold |=> cellConvert)
    else $error("convert dropped before done");
  chan_stable_a: assert property (cellConvert && $past(cellConvert)
    |-> $stable(cellChannel)) else $error("channel moved in conversion");
  cell_powered_a: assert property (cellSample || cellConvert
    |-> cellPowerOn)
    else $error("cell unpowered while working");
  dma_hold_a: assert property (dmaRequest && !dmaAck |=> dmaRequest)
    else $error("dma request dropped without ack");
  dma_width_a: assert property ($stable(modeQ.lowResolution)
    |-> dmaWide == !modeQ.lowResolution) else $error("dma width wrong");
endmodule : adc_seq_checker
bind adc_sequencer_control adc_seq_checker #(
  .CHANNELS(CHANNELS), .COUNT_W(COUNT_W)) chk (.core_clk(core_clk),
  .sys_rst(sys_rst), .clkEn(clkEn), .busReq(busReq), .rdata(rdata),
  .cellPowerOn(cellPowerOn), .cellSample(cellSample),
  .cellConvert(cellConvert), .cellChannel(cellChannel),
  .cellDone(cellDone), .dmaRequest(dmaRequest), .dmaWide(dmaWide),
  .dmaAck(dmaAck));
`default_nettype wire

/* verification/tb_adc_sequencer_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_params.svh"
module tb_adc_sequencer_control;
  import adc_seq_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clkEn = 1'b1;
  bus_req_s    busReq = '0;
  logic [2:0]  timerWaveOut = 3'h0;
  logic        externalTriggerIn = 1'b0;
  logic [31:0] rdata;
  logic        cellPowerOn, cellSample, cellConvert, cellDone;
  logic        dmaRequest, dmaWide, dmaAck, irq;
  logic [2:0]  cellChannel;
  logic [9:0]  cellResult;
  logic        rdSeen = 1'b0;
  logic [15:0] seed = 16'h706a;
  logic [31:0] expQ[$];
  int          miscompares = 0;
  int          check_count = 0;
  int          doneCnt = 0;
  always #20 core_clk = ~core_clk;
  adc_sequencer_control dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .busReq(busReq), .rdata(rdata),
    .timerWaveOut(timerWaveOut), .externalTriggerIn(externalTriggerIn),
    .cellPowerOn(cellPowerOn), .cellSample(cellSample),
    .cellConvert(cellConvert), .cellChannel(cellChannel),
    .cellDone(cellDone), .cellResult(cellResult),
    .dmaRequest(dmaRequest), .dmaWide(dmaWide), .dmaAck(dmaAck),
    .irq(irq));
  adc_cell_model partner (.core_clk(core_clk), .sys_rst(sys_rst),
    .cellConvert(cellConvert), .cellChannel(cellChannel),
    .dmaRequest(dmaRequest), .cellDone(cellDone),
    .cellResult(cellResult), .dmaAck(dmaAck));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic test_done();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) busReq.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge core_clk) busReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk) busReq.rd <= 1'b0;
  endtask : rd
  task automatic pulse(input logic [3:0] w);
    @(posedge core_clk) {externalTriggerIn, timerWaveOut} <= w;
    repeat (4) @(posedge core_clk);
    {externalTriggerIn, timerWaveOut} <= 4'h0;
    repeat (30) @(posedge core_clk);
  endtask : pulse
  task automatic waitDone(input int n);
    for (int i = 0; i < 5000 && doneCnt < n; i++) @(posedge core_clk);
    chk(doneCnt >= n, "conversions missing");
    if (doneCnt < n) test_done();
    else repeat (40) @(posedge core_clk);
  endtask : waitDone
  // ---------------------------------------------------------------
  // read answers are compared against the oldest expectation
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    rdSeen <= busReq.rd;
    if (cellDone && cellConvert) doneCnt <= doneCnt + 1;
  end
  always @(negedge core_clk) if (rdSeen) chk(rdata === expQ.pop_front(),
    "read data mismatch");
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      wr(`OFS_MODE, {seed, ~seed});
      rd(`OFS_MODE, {seed, ~seed} & `MODE_WRITE_MASK);
    end
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'h0);
    wr(`OFS_DMA_COUNT, 32'h4);
    wr(`OFS_DMA_NEXT, 32'h0);
    // a write while frozen must leave no trace
    clkEn <= 1'b0;
    wr(`OFS_CH_ENABLE, 32'h02);
    clkEn <= 1'b1;
    wr(`OFS_CH_ENABLE, 32'h05);
    wr(`OFS_CH_ENABLE, 32'h00);
    rd(`OFS_CH_STATE, 32'h05);
    wr(`OFS_CH_DISABLE, 32'h0c);
    rd(`OFS_CH_STATE, 32'h01);
    wr(`OFS_CH_ENABLE, 32'h04);
    rd(`OFS_CH_STATE, 32'h05);
    wr(`OFS_MODE, 32'h0200010c);
    pulse(4'h8);
    wr(`OFS_CONTROL, 32'h0);
    repeat (100) @(posedge core_clk);
    chk(doneCnt == 0, "conversion without start");
    wr(`OFS_CONTROL, 32'h2);
    waitDone(2);
    wr(`OFS_IRQ_ENABLE, 32'h0);
    repeat (3) @(posedge core_clk);
    chk(irq === 1'b0, "irq without enable");
    wr(`OFS_IRQ_ENABLE, 32'h10000);
    repeat (3) @(posedge core_clk);
    chk(irq === 1'b1, "irq missing");
    rd(`OFS_IRQ_MASK, 32'h10000);
    rd(`OFS_FLAGS, 32'h00030005);
    rd(`OFS_LAST_RESULT, 32'h2a2);
    rd(`OFS_FLAGS, 32'h00000001);
    repeat (3) @(posedge core_clk);
    chk(irq === 1'b0, "irq stuck");
    wr(`OFS_MODE, 32'h0200011d);
    pulse(4'h8);
    waitDone(4);
    rd(`OFS_FLAGS, 32'h000f0105);
    rd(`OFS_LAST_RESULT, 32'h0a8);
    rd(`OFS_FLAGS, 32'h000c0001);
    wr(`OFS_DMA_COUNT, 32'h3);
    rd(`OFS_FLAGS, 32'h00000001);
    for (int c = 0; c < 4; c++) begin
      wr(`OFS_MODE, 32'h02000121 | (c << 1));
      pulse(c < 3 ? 4'(1 << c) : 4'hf);
      if (c < 3) waitDone(6 + 2 * c);
      chk(doneCnt == 6 + 2 * (c < 3 ? c : 2), "trigger select");
      chk(cellPowerOn === 1'b0, "cell left powered");
    end
    // software reset returns the registers to their reset values
    wr(`OFS_CONTROL, 32'h1);
    rd(`OFS_MODE, 32'h0);
    rd(`OFS_CH_STATE, 32'h0);
    rd(`OFS_FLAGS, 32'h00080000);
    test_done();
  end
endmodule : tb_adc_sequencer_control
`default_nettype wire
